// ==== inc/ecp_pkg.sv ====
package ecp_pkg;
    localparam int WORD_W       = 8;
    localparam int FIFO_DEPTH   = 16;
    localparam int STAGE_DEPTH  = 4;
    localparam int FIFO_AW      = 4;
    localparam int STAGE_AW     = 2;
    localparam int RLE_W        = 7;
    localparam int TAG_BIT      = 8;
    localparam int ITEM_W       = 9;
    localparam int RLE_FLAG_BIT = 7;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [6:0] RUN_ZERO = 7'h00;
    localparam logic [6:0] RUN_ONE  = 7'h01;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_ONE  = 5'h01;
    localparam logic [4:0] CNT_FULL = 5'h10;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SPP = 2'h1;
    localparam logic [1:0] MODE_ECP = 2'h2;
endpackage

// ==== rtl/ecp_fifo.sv ====
`timescale 1ns/1ps
module ecp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [AW:0]      level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    // read data comes straight from the addressed word; register stage costs a cycle
    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_reg];
    assign level     = cnt_reg;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (int'(wr_reg) == DEPTH - 1) ? '0 : wr_reg + AW'(1);
            end
            if (pop) begin
                rd_reg <= (int'(rd_reg) == DEPTH - 1) ? '0 : rd_reg + AW'(1);
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ==== rtl/ecp_link.sv ====
`timescale 1ns/1ps
// Function
// - no negotiation; automatic burst channel with dma requests both directions
// - both directions buffered through one sixteen byte fifo
// - compatibility mode strobe handshake generated automatically per byte
// - in ecp forward, run-length byte consumed, next data byte repeated that many times
// - host strobe asserting edge latches byte, interlocked with busy
// - in reverse, autofeed asserted requests a byte, interlocked with nack
// - in ecp forward, autofeed marks address versus data byte
// - ninit low selects reverse, high forward
// - host drives data bus only after reverse acknowledge says so
// - select-in held deasserted throughout ecp mode
// - fault input asserted raises an error interrupt
// - fault during forward is only a reverse hint; host keeps direction
// - data lines carry address or data bytes per handshake; run-length bytes never reach them
// - port word is eight bits wide
module ecp_link (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic [1:0] mode,
    input  wire logic       reverse_req,
    input  wire logic [7:0] host_wdata,
    input  wire logic       host_wtag,
    input  wire logic       host_wvalid,
    output logic            host_wready,
    output logic [7:0]      host_rdata,
    output logic            host_rtag,
    output logic            host_rvalid,
    input  wire logic       host_rready,
    output logic            dma_req,
    output logic            fifo_full,
    output logic            fifo_empty,
    output logic            error_irq,
    output logic            reverse_hint,
    output logic            dir_reverse,
    output logic [7:0]      pd_out,
    output logic            pd_oe_n,
    input  wire logic [7:0] pd_in,
    output logic            nstrobe,
    output logic            nautofd,
    output logic            ninit,
    output logic            nselectin,
    input  wire logic       busy,
    input  wire logic       nack,
    input  wire logic       perror,
    input  wire logic       nfault
);
    // ============================================================
    // state
    // ============================================================
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_SETUP = 6'b000010,
        ST_STRB  = 6'b000100,
        ST_HOLD  = 6'b001000,
        ST_TURN  = 6'b010000,
        ST_REV   = 6'b100000
    } ecp_state_t;

    ecp_state_t state_reg;
    logic       rev_reg;
    logic       rev_ack_reg;
    logic [7:0] pd_reg;
    logic       strobe_reg;
    logic       afd_reg;
    logic [6:0] run_reg;
    logic       run_act_reg;
    logic       fault_d_reg;
    logic       irq_reg;
    logic [7:0] rd_data_reg;
    logic       rd_tag_reg;
    logic       rd_valid_reg;

    // ============================================================
    // main fifo: sixteen bytes, shared by both directions
    // ============================================================
    logic [8:0] mf_in;
    logic       mf_in_valid;
    logic       mf_in_ready;
    logic [8:0] mf_out;
    logic       mf_out_valid;
    logic       mf_out_ready;
    logic [4:0] mf_level;
    logic [8:0] sf_out;
    logic       sf_out_valid;
    logic       sf_out_ready;
    logic       sf_in_valid;
    logic       sf_in_ready;

    // forward data is written by the host; reverse data comes from the stage fifo
    assign mf_in       = rev_reg ? sf_out : {host_wtag, host_wdata};
    assign mf_in_valid = rev_reg ? sf_out_valid : host_wvalid;
    assign sf_out_ready = rev_reg && mf_in_ready;
    assign host_wready = !rev_reg && mf_in_ready;

    ecp_fifo #(
        .WIDTH (ecp_pkg::ITEM_W),
        .DEPTH (ecp_pkg::FIFO_DEPTH),
        .AW    (ecp_pkg::FIFO_AW)
    ) u_main (
        .clock     (clock),
        .nrst      (nrst),
        .in_data   (mf_in),
        .in_valid  (mf_in_valid),
        .in_ready  (mf_in_ready),
        .out_data  (mf_out),
        .out_valid (mf_out_valid),
        .out_ready (mf_out_ready),
        .level     (mf_level)
    );

    // ============================================================
    // reverse staging fifo: four words between the pins and the main fifo
    // ============================================================
    ecp_fifo #(
        .WIDTH (ecp_pkg::ITEM_W),
        .DEPTH (ecp_pkg::STAGE_DEPTH),
        .AW    (ecp_pkg::STAGE_AW)
    ) u_stage (
        .clock     (clock),
        .nrst      (nrst),
        .in_data   ({busy, pd_in}),
        .in_valid  (sf_in_valid),
        .in_ready  (sf_in_ready),
        .out_data  (sf_out),
        .out_valid (sf_out_valid),
        .out_ready (sf_out_ready),
        .level     ()
    );

    // ============================================================
    // host read register: reverse bytes reach the host from flip-flops
    // ============================================================
    // costs one cycle of latency per reverse byte, but a byte still leaves
    // every cycle while the host keeps ready high
    logic rd_take;

    assign rd_take = rev_reg && mf_out_valid && (!rd_valid_reg || host_rready);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rd_valid_reg <= 1'b0;
        end else if (rd_take) begin
            rd_valid_reg <= 1'b1;
        end else if (host_rready || !rev_reg) begin
            // leaving ecp mode discards a byte that nobody will read
            rd_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rd_data_reg <= ecp_pkg::DATA_RST;
            rd_tag_reg  <= 1'b0;
        end else if (rd_take) begin
            rd_data_reg <= mf_out[ecp_pkg::WORD_W-1:0];
            rd_tag_reg  <= mf_out[ecp_pkg::TAG_BIT];
        end
    end

    assign host_rdata  = rd_data_reg;
    assign host_rtag   = rd_tag_reg;
    assign host_rvalid = rd_valid_reg;
    assign fifo_full   = (mf_level == ecp_pkg::CNT_FULL);
    assign fifo_empty  = (mf_level == ecp_pkg::CNT_ZERO);
    // outside off mode, dma is asked for whenever the fifo can take or give a byte
    assign dma_req     = (mode != ecp_pkg::MODE_OFF)
                         && (rev_reg ? (mf_out_valid || rd_valid_reg)
                                     : mf_in_ready);

    // ============================================================
    // forward byte sequencer
    // ============================================================
    logic fwd_ok;
    logic is_rle;
    logic ecp_on;
    logic expand;

    assign ecp_on  = (mode == ecp_pkg::MODE_ECP);
    assign fwd_ok  = !rev_reg && !rev_ack_reg && (mode != ecp_pkg::MODE_OFF);
    // run-length byte: address-tagged with top bit clear
    assign is_rle  = mf_out[ecp_pkg::TAG_BIT] && !mf_out[ecp_pkg::RLE_FLAG_BIT];
    // a pending run repeats this byte instead of popping it until the last copy
    assign expand  = run_act_reg;
    assign mf_out_ready = rev_reg ? (!rd_valid_reg || host_rready)
                        : (state_reg == ST_IDLE && fwd_ok && mf_out_valid
                           && ((ecp_on && is_rle) || !expand))
                       || (state_reg == ST_HOLD && !strobe_reg && expand
                           && run_reg == ecp_pkg::RUN_ZERO && !busy);

    // count n means n+1 copies; the register holds copies still to come, so a
    // count of 127 needs no eighth bit
    always_ff @(posedge clock) begin
        if (!nrst) begin
            run_reg     <= ecp_pkg::RUN_ZERO;
            run_act_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && fwd_ok && mf_out_valid && ecp_on && is_rle) begin
            run_reg     <= mf_out[ecp_pkg::RLE_W-1:0];
            run_act_reg <= 1'b1;
        end else if (state_reg == ST_HOLD && !busy && expand) begin
            if (run_reg == ecp_pkg::RUN_ZERO) begin
                run_act_reg <= 1'b0;
            end else begin
                run_reg <= run_reg - ecp_pkg::RUN_ONE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg  <= ST_IDLE;
            pd_reg     <= ecp_pkg::DATA_RST;
            strobe_reg <= 1'b0;
            afd_reg    <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    strobe_reg <= 1'b0;
                    if (rev_reg) begin
                        afd_reg   <= 1'b0;
                        state_reg <= ST_REV;
                    end else if (fwd_ok && mf_out_valid && !(ecp_on && is_rle)) begin
                        pd_reg    <= mf_out[ecp_pkg::WORD_W-1:0];
                        // autofeed low marks an address byte in ecp forward
                        afd_reg   <= ecp_on && mf_out[ecp_pkg::TAG_BIT];
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // wait for busy low before strobing: interlocked
                    if (!busy) begin
                        strobe_reg <= 1'b1;
                        state_reg  <= ST_STRB;
                    end
                end
                ST_STRB: begin
                    if (busy) begin
                        strobe_reg <= 1'b0;
                        state_reg  <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (!busy) begin
                        afd_reg   <= 1'b0;
                        // repeat the held byte for a pending run
                        state_reg <= (expand && run_reg != ecp_pkg::RUN_ZERO)
                                     ? ST_SETUP : ST_IDLE;
                    end
                end
                ST_TURN: begin
                    state_reg <= ST_IDLE;
                end
                ST_REV: begin
                    // host ack asserted requests a byte; released after nack answers
                    if (!rev_reg) begin
                        afd_reg   <= 1'b0;
                        state_reg <= ST_TURN;
                    end else if (!afd_reg && nack && sf_in_ready && reverse_req) begin
                        afd_reg <= 1'b1;
                    end else if (afd_reg && !nack) begin
                        afd_reg <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // capture on the interlocked nack fall while the request stands
    assign sf_in_valid = (state_reg == ST_REV) && rev_reg && afd_reg && !nack;

    // ============================================================
    // direction control
    // ============================================================
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rev_reg <= 1'b0;
        end else if (!ecp_on) begin
            rev_reg <= 1'b0;
        end else if (reverse_req && !rev_reg && state_reg == ST_IDLE && !mf_out_valid) begin
            // turn only with the forward path drained; the fault hint never turns it
            rev_reg <= 1'b1;
        end else if (!reverse_req && rev_reg && state_reg == ST_REV && nack
                     && !mf_out_valid && !sf_out_valid && !rd_valid_reg) begin
            // nack high: no byte is mid-handshake, so a standing request may be dropped
            rev_reg <= 1'b0;
        end
    end

    // pending until perror agrees with forward; held set while the direction is reverse
    always_ff @(posedge clock) begin
        if (!nrst) begin
            // bus stays released until perror has been seen high after reset
            rev_ack_reg <= 1'b1;
        end else begin
            rev_ack_reg <= rev_reg || !perror;
        end
    end

    assign dir_reverse = rev_reg;
    assign ninit       = !rev_reg;
    assign nselectin   = ecp_on ? 1'b1 : 1'b0;
    assign nstrobe     = !strobe_reg;
    assign nautofd     = !afd_reg;
    assign pd_out      = pd_reg;
    assign pd_oe_n     = rev_reg || rev_ack_reg;

    // ============================================================
    // fault: error interrupt and reverse hint
    // ============================================================
    // previous level; reset to the idle level so release makes no false edge
    always_ff @(posedge clock) begin
        if (!nrst) begin
            fault_d_reg <= 1'b1;
        end else begin
            fault_d_reg <= nfault;
        end
    end

    // a level, not a sticky flag: it drops once the fault input is released
    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= !nfault;
        end
    end

    assign error_irq    = irq_reg;
    assign reverse_hint = ecp_on && !rev_reg && !nfault && fault_d_reg;
endmodule

// ==== tb/ecp_link_chk.sv ====
`timescale 1ns/1ps
// ====================
// link protocol checks
module ecp_link_chk (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic [1:0] mode,
    input wire logic       error_irq,
    input wire logic       reverse_hint,
    input wire logic       dir_reverse,
    input wire logic [7:0] pd_out,
    input wire logic       pd_oe_n,
    input wire logic       nstrobe,
    input wire logic       nautofd,
    input wire logic       ninit,
    input wire logic       nselectin,
    input wire logic       busy,
    input wire logic       nack,
    input wire logic       perror,
    input wire logic       nfault
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    sequence s_strobe_wait;
        !nstrobe && !busy;
    endsequence
    sequence s_rev_take;
        dir_reverse && $fell(nack);
    endsequence
    property p_selin; mode == ecp_pkg::MODE_ECP |-> nselectin; endproperty
    a_selin: assert property (p_selin) else $error("select-in low in ecp mode");
    property p_hiz; (dir_reverse || !ninit) |-> pd_oe_n; endproperty
    a_hiz: assert property (p_hiz) else $error("data bus driven while turned");
    property p_dir; $rose(dir_reverse) |-> !ninit && $past(nstrobe); endproperty
    a_dir: assert property (p_dir) else $error("reverse without direction low");
    property p_bus_wait; !pd_oe_n |-> $past(perror); endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus driven before ack");
    property p_stb_go; $fell(nstrobe) |-> !$past(busy); endproperty
    a_stb_go: assert property (p_stb_go) else $error("strobe fell while busy");
    property p_stb_hold; s_strobe_wait |=> !nstrobe; endproperty
    a_stb_hold: assert property (p_stb_hold) else $error("strobe left early");
    property p_data_hold; !nstrobe |=> $stable(pd_out) && $stable(nautofd); endproperty
    a_data_hold: assert property (p_data_hold) else $error("byte moved under strobe");
    property p_irq; 1'b1 |=> error_irq == !$past(nfault); endproperty
    a_irq: assert property (p_irq) else $error("error flag not following fault");
    // autofeed is released one edge after nack is seen low, so allow a short slot
    property p_rev_ack; s_rev_take |-> ##[1:3] nautofd; endproperty
    a_rev_ack: assert property (p_rev_ack) else $error("reverse byte not acked");
    property p_hint; reverse_hint |-> !nfault && !dir_reverse && mode == ecp_pkg::MODE_ECP;
    endproperty
    a_hint: assert property (p_hint) else $error("hint outside ecp forward");
endmodule

bind ecp_link ecp_link_chk u_chk (.clock, .nrst, .mode, .error_irq, .reverse_hint,
    .dir_reverse, .pd_out, .pd_oe_n, .nstrobe, .nautofd, .ninit, .nselectin, .busy,
    .nack, .perror, .nfault);

// ==== tb/ecp_periph_model.sv ====
`timescale 1ns/1ps
// =================
// peripheral model
module ecp_periph_model (
    input  wire logic       clock,
    input  wire logic       nstrobe,
    input  wire logic       nautofd,
    input  wire logic       ninit,
    input  wire logic [7:0] pd_out,
    output logic            busy = 1'b0,
    output logic            nack = 1'b1,
    output logic            perror = 1'b1,
    output logic [7:0]      pd_in = 8'hff
);
    logic [8:0] cap_q[$];
    logic [8:0] rev_q[$];
    logic       stall = 1'b0;
    int         lag = 0;
    always @(negedge clock) begin
        // released bus keeps toggling so a stale byte cannot look valid
        if (nack)
            pd_in <= ~pd_in;
        perror <= ninit;
        if (!ninit) begin
            if (!perror && !nautofd && nack && rev_q.size() > 0) begin
                {busy, pd_in} <= rev_q.pop_front();
                nack <= 1'b0;
            end else if (!nack && nautofd)
                nack <= 1'b1;
        end else if (!nstrobe && !busy) begin
            cap_q.push_back({nautofd, pd_out});
            repeat (lag) @(negedge clock);
            busy <= 1'b1;
        end else if (nstrobe && busy != stall)
            busy <= stall;
    end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
// ==============
// link testbench
module tb_top;
    logic       clock = 1'b0;
    logic       nrst = 1'b0;
    logic [1:0] mode = ecp_pkg::MODE_OFF;
    logic       reverse_req = 1'b0;
    logic [7:0] host_wdata = 8'h00;
    logic       host_wtag = 1'b0;
    logic       host_wvalid = 1'b0;
    logic       host_rready = 1'b0;
    logic       nfault = 1'b1;
    logic [7:0] host_rdata, pd_out, pd_in;
    logic       host_rtag, host_rvalid, host_wready, dma_req, fifo_full, fifo_empty;
    logic       error_irq, reverse_hint, dir_reverse, pd_oe_n, nstrobe, nautofd;
    logic       ninit, nselectin, busy, nack, perror, took;
    int         num_errors = 0;
    int         check_count = 0;
    always #4 clock = ~clock;
    ecp_link u_dut (.clock, .nrst, .mode, .reverse_req, .host_wdata, .host_wtag,
        .host_wvalid, .host_wready, .host_rdata, .host_rtag, .host_rvalid, .host_rready,
        .dma_req, .fifo_full, .fifo_empty, .error_irq, .reverse_hint, .dir_reverse,
        .pd_out, .pd_oe_n, .pd_in, .nstrobe, .nautofd, .ninit, .nselectin, .busy, .nack,
        .perror, .nfault);
    ecp_periph_model u_per (.clock, .nstrobe, .nautofd, .ninit, .pd_out, .busy, .nack,
        .perror, .pd_in);
    task automatic complete_run;
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_w(input string n, input logic [8:0] e, input logic [8:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_b(input string n, input logic e, input logic g);
        chk_w(n, {8'h00, e}, {8'h00, g});
    endtask
    task automatic hang(input string n);
        chk_w(n, 9'h000, 9'h1ff);
        complete_run();
    endtask
    // valid stays up between calls so back-to-back writes never drop it
    task automatic wr(input logic t, input logic [7:0] d, input int lim);
        int n;
        n = 0;
        host_wtag = t;
        host_wdata = d;
        host_wvalid = 1'b1;
        while (host_wready !== 1'b1 && n < lim) begin
            @(negedge clock);
            n++;
        end
        took = n < lim;
        if (took)
            @(negedge clock);
        else if (lim > 9)
            hang("write");
    endtask
    task automatic rd(input logic [8:0] e);
        int n;
        n = 0;
        while (host_rvalid !== 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        if (n == 100)
            hang("read");
        chk_w("rdata", e, {host_rtag, host_rdata});
        @(negedge clock);
    endtask
    task automatic wait_cap(input int c);
        int n;
        n = 0;
        while (u_per.cap_q.size() < c && n < 400) begin
            @(negedge clock);
            n++;
        end
        if (n == 400)
            hang("capture");
        repeat (20) @(negedge clock);
        chk_w("count", 9'(c), 9'(u_per.cap_q.size()));
    endtask
    task automatic t_fwd;
        mode = ecp_pkg::MODE_ECP;
        u_per.lag = 3;
        wr(1'b0, 8'h3c, 50);
        wr(1'b1, 8'h85, 50);
        wr(1'b0, 8'hc3, 50);
        host_wvalid = 1'b0;
        wait_cap(3);
        chk_w("data", 9'h13c, u_per.cap_q[0]);
        chk_w("addr", 9'h085, u_per.cap_q[1]);
        chk_w("data", 9'h1c3, u_per.cap_q[2]);
        chk_b("nselectin", 1'b1, nselectin);
        u_per.lag = 0;
        u_per.cap_q.delete();
    endtask
    task automatic t_rle;
        wr(1'b1, 8'h02, 50);
        wr(1'b0, 8'ha5, 50);
        wr(1'b1, 8'h00, 50);
        wr(1'b0, 8'h5a, 50);
        host_wvalid = 1'b0;
        wait_cap(4);
        for (int i = 0; i < 3; i++)
            chk_w("run", 9'h1a5, u_per.cap_q[i]);
        chk_w("run", 9'h15a, u_per.cap_q[3]);
        u_per.cap_q.delete();
    endtask
    task automatic t_fill;
        int n;
        n = 0;
        u_per.stall = 1'b1;
        repeat (4) @(negedge clock);
        do begin
            wr(1'b0, 8'(n), 8);
            n = n + int'(took);
        end while (took && n < 40);
        chk_b("fifo_full", 1'b1, fifo_full);
        chk_b("wready", 1'b0, host_wready);
        chk_b("dma_req", 1'b0, dma_req);
        chk_b("depth", 1'b1, n >= 16);
        host_wvalid = 1'b0;
        u_per.stall = 1'b0;
        wait_cap(n);
        for (int i = 0; i < n; i++)
            chk_w("drain", {1'b1, 8'(i)}, u_per.cap_q[i]);
        chk_b("fifo_empty", 1'b1, fifo_empty);
        u_per.cap_q.delete();
    endtask
    task automatic t_rev;
        u_per.rev_q.push_back(9'h15e);
        u_per.rev_q.push_back(9'h077);
        reverse_req = 1'b1;
        host_rready = 1'b1;
        rd(9'h15e);
        rd(9'h077);
        chk_b("ninit", 1'b0, ninit);
        chk_b("dir", 1'b1, dir_reverse);
        chk_b("pd_oe_n", 1'b1, pd_oe_n);
        host_rready = 1'b0;
        reverse_req = 1'b0;
        wr(1'b0, 8'h42, 50);
        host_wvalid = 1'b0;
        wait_cap(1);
        chk_w("turn", 9'h142, u_per.cap_q[0]);
        u_per.cap_q.delete();
    endtask
    task automatic t_fault;
        nfault = 1'b0;
        #1;
        chk_b("hint", 1'b1, reverse_hint);
        repeat (3) @(negedge clock);
        chk_b("error_irq", 1'b1, error_irq);
        chk_b("hint", 1'b0, reverse_hint);
        chk_b("dir", 1'b0, dir_reverse);
        nfault = 1'b1;
        repeat (3) @(negedge clock);
        chk_b("error_irq", 1'b0, error_irq);
    endtask
    initial begin
        repeat (4) @(negedge clock);
        nrst = 1'b1;
        chk_b("nstrobe", 1'b1, nstrobe);
        chk_b("ninit", 1'b1, ninit);
        chk_b("pd_oe_n", 1'b1, pd_oe_n);
        chk_b("dma_req", 1'b0, dma_req);
        chk_b("fifo_empty", 1'b1, fifo_empty);
        t_fwd();
        t_rle();
        t_fill();
        t_rev();
        t_fault();
        mode = ecp_pkg::MODE_SPP;
        wr(1'b0, 8'h96, 50);
        host_wvalid = 1'b0;
        wait_cap(1);
        chk_w("compat", 9'h096, {1'b0, u_per.cap_q[0][7:0]});
        complete_run();
    end
endmodule
